// File: hw/lsfu_logic_block.sv
// Logic block: four slices, wide function combiners, distributed memory
// tables and the region source mux that feeds clock, enable and set/reset.
// Assumes config and user inputs are synchronous to clk_sys; source lines are not.
//
// Functional notes
// - Slices 0-2 registered; slice 3 tables only.
// - Only RAM-capable block slices 0-2 do RAM.
// - Tables combine into five to eight inputs.
// - Set/reset sync or async; clock select, chip-select.
// - Registers edge or level, either polarity.
// - Slices 0-2: fourteen inputs, seven outputs, carry.
// - Slice 3: ten inputs, four outputs, no carry.
// - Registers start from configured preset or clear.
// - Eight region lines; 0-3 control, 4-7 clock.
// - Line 7 also control; lines 0-2 also clock.
// - Six lines from pads, rest from routing.
`timescale 1ns/1ps
module lsfu_logic_block
  import lsfu_pkg::*;
#(
  parameter bit RAM_CAPABLE = 1'b1
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rstn,
  input  wire logic [PAD_SRC-1:0]       src_pad,
  input  wire logic [ROUTE_SRC-1:0]     src_route,
  input  wire logic [2:0]               clk_sel,
  input  wire logic [2:0]               ce_sel,
  input  wire logic [2:0]               lsr_sel,
  input  wire logic                     ce_force,
  input  wire logic                     lsr_off,
  input  wire logic                     reg_edge,
  input  wire logic                     reg_neg,
  input  wire logic                     lsr_async,
  input  wire logic [2*REG_SLICES-1:0]  init_val,
  input  wire logic [2*SLICES-1:0]      mode_cfg,
  input  wire logic                     cfg_we,
  input  wire logic [2:0]               cfg_sel,
  input  wire logic [TBL_W-1:0]         cfg_data,
  input  wire logic                     ram_we,
  input  wire logic                     ram_cs,
  input  wire logic [LUT_IN-1:0]        ram_waddr,
  input  wire logic [2*REG_SLICES-1:0]  ram_wdata,
  input  wire logic [2*SLICES*LUT_IN-1:0] lut_in,
  input  wire logic [2*SLICES-1:0]      m_in,
  input  wire logic                     fci,
  input  wire logic                     wide_in,
  output logic [2*SLICES-1:0]           f,
  output logic [2*REG_SLICES-1:0]       q,
  output logic [SLICES-1:0]             ofx,
  output logic                          fco,
  output logic [1:0]                    lut6,
  output logic                          lut7,
  output logic                          lut8,
  output logic                          mode_err,
  output logic                          sel_err
);
  typedef struct packed {
    logic [2*SLICES-1:0][TBL_W-1:0] tbl;
  } lsfu_blk_st_t;

  lsfu_blk_st_t              st_reg;
  lsfu_blk_st_t              st_next;
  lsfu_mode_t                mode_req [SLICES];
  lsfu_mode_t                mode_eff [SLICES];
  logic [SLICES-1:0]         mode_bad;
  logic [REG_SLICES:0]       carry;
  logic [SLICES-1:0]         fco_s;
  logic [2*SLICES-1:0]       q_s;
  logic                      clk_lvl;
  logic                      clk_rise;
  logic                      clk_fall;
  logic                      ce;
  logic                      local_set_reset;
  logic                      wr_strobe;

  // Region source mux for clock, enable and set/reset
  lsfu_src_mux u_src_mux (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .src_pad   (src_pad),
    .src_route (src_route),
    .clk_sel   (clk_sel),
    .ce_sel    (ce_sel),
    .lsr_sel   (lsr_sel),
    .ce_force  (ce_force),
    .lsr_off   (lsr_off),
    .clk_lvl   (clk_lvl),
    .clk_rise  (clk_rise),
    .clk_fall  (clk_fall),
    .ce        (ce),
    .local_set_reset       (local_set_reset),
    .sel_err   (sel_err)
  );

  // Requested modes are clipped to what each slice and block allow
  always_comb begin
    for (int s = 0; s < SLICES; s++) begin
      mode_req[s] = lsfu_mode_t'(mode_cfg[2*s +: 2]);
      mode_eff[s] = lsfu_legal(s, mode_req[s], RAM_CAPABLE);
      mode_bad[s] = (mode_eff[s] != mode_req[s]);
    end
  end
  assign mode_err = |mode_bad;

  // Memory writes take the register clock edge of the reg_neg polarity even when reg_edge selects level, gated by chip-select
  assign wr_strobe = ram_we & ram_cs & (reg_neg ? clk_fall : clk_rise);

  // Configuration load wins over a user write to the same table
  always_comb begin
    st_next = st_reg;
    for (int k = 0; k < 2*REG_SLICES; k++) begin
      if (wr_strobe && mode_eff[k/2] == LSFU_RAM) begin
        st_next.tbl[k][ram_waddr] = ram_wdata[k];
      end
    end
    if (cfg_we) begin
      st_next.tbl[cfg_sel] = cfg_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '{default: TBL_RST};
    end else begin
      st_reg <= st_next;
    end
  end

  // Carry chain runs through the registered slices only
  assign carry[0] = fci;
  genvar g;
  generate
    for (g = 0; g < SLICES; g++) begin : g_slice
      lsfu_slice #(
        .HAS_REG (g < REG_SLICES)
      ) u_slice (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .tbl0      (st_reg.tbl[2*g]),
        .tbl1      (st_reg.tbl[2*g+1]),
        .lut_a     (lut_in[8*g +: LUT_IN]),
        .lut_b     (lut_in[8*g+4 +: LUT_IN]),
        .m0        (m_in[2*g]),
        .mode      (mode_eff[g]),
        .fci       ((g < REG_SLICES) ? carry[(g < REG_SLICES) ? g : 0] : 1'b0),
        .reg_edge  (reg_edge),
        .reg_neg   (reg_neg),
        .lsr_async (lsr_async),
        .init_val  ((g < REG_SLICES) ? init_val[2*((g < REG_SLICES) ? g : 0) +: 2] : Q_RST),
        .clk_lvl   (clk_lvl),
        .clk_rise  (clk_rise),
        .clk_fall  (clk_fall),
        .ce        (ce),
        .local_set_reset       (local_set_reset),
        .f         (f[2*g +: 2]),
        .ofx       (ofx[g]),
        .q         (q_s[2*g +: 2]),
        .fco       (fco_s[g])
      );
      if (g < REG_SLICES) begin : g_carry
        assign carry[g+1] = fco_s[g];
      end
    end
  endgenerate
  assign fco = carry[REG_SLICES];
  assign q   = q_s[2*REG_SLICES-1:0];

  // Wide functions: pairs, quads, whole block, then the neighbour block
  assign lut6[0] = m_in[1] ? ofx[1] : ofx[0];
  assign lut6[1] = m_in[5] ? ofx[3] : ofx[2];
  assign lut7    = m_in[3] ? lut6[1] : lut6[0];
  assign lut8    = m_in[7] ? wide_in : lut7;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  chk_top_slice_mode: assert property (mode_eff[3] == LSFU_LOGIC || mode_eff[3] == LSFU_ROM)
    else $error("top slice left in a mode it lacks");
  chk_ram_capable: assert property (!RAM_CAPABLE |-> mode_eff[0] != LSFU_RAM
                                    && mode_eff[1] != LSFU_RAM && mode_eff[2] != LSFU_RAM)
    else $error("logic-only block slice acting as memory");
  chk_ram_write_land: assert property (wr_strobe && !cfg_we && mode_eff[0] == LSFU_RAM
                                       |=> st_reg.tbl[0][$past(ram_waddr)] == $past(ram_wdata[0]))
    else $error("memory write did not reach the table");
  chk_rom_write_block: assert property (wr_strobe && !cfg_we && mode_eff[1] == LSFU_ROM
                                        |=> $stable(st_reg.tbl[2]))
    else $error("table in read-only mode was written");
  chk_no_cs_write: assert property (!ram_cs && !cfg_we |=> $stable(st_reg.tbl))
    else $error("tables changed without chip-select");
  chk_lut7_select: assert property (lut7 == (m_in[3] ? (m_in[5] ? ofx[3] : ofx[2])
                                             : (m_in[1] ? ofx[1] : ofx[0])))
    else $error("seven-input combine picked the wrong quad");
  chk_carry_span: assert property (mode_eff[0] != LSFU_RIPPLE |-> fco_s[0] == 1'b0)
    else $error("carry out active outside ripple mode");
  chk_top_no_carry: assert property (fco_s[3] == 1'b0 && q_s[7:6] == Q_RST)
    else $error("top slice drives carry or register");

  cov_ram_write: cover property (wr_strobe && mode_eff[0] == LSFU_RAM);
  cov_lut8_far: cover property (m_in[7] && lut8 != lut7);
  cov_ripple_out: cover property (mode_eff[2] == LSFU_RIPPLE && fco);
  cov_mode_clip: cover property (mode_err);
endmodule

// File: hw/lsfu_pkg.sv
// Package for the logic block slice cluster and its region source mux.
// Assumes one system clock; all source lines arrive from outside that domain.
package lsfu_pkg;
  localparam int SLICES       = 4;
  localparam int REG_SLICES   = 3;
  localparam int TBL_W        = 16;
  localparam int LUT_IN       = 4;
  localparam int SRC_LINES    = 8;
  localparam int PAD_SRC      = 6;
  localparam int ROUTE_SRC    = SRC_LINES - PAD_SRC;
  // Pin counts of a register slice and of the top slice
  localparam int REG_SLICE_IN  = 14;
  localparam int REG_SLICE_OUT = 7;
  localparam int TOP_SLICE_IN  = 10;
  localparam int TOP_SLICE_OUT = 4;
  // Lines usable as clock (0-2, 4-7) and as control (0-3, 7)
  localparam logic [SRC_LINES-1:0] CLK_LINE_OK = 8'hF7;
  localparam logic [SRC_LINES-1:0] CTL_LINE_OK = 8'h8F;
  // Values after reset
  localparam logic [TBL_W-1:0] TBL_RST = 16'h0000;
  localparam logic [1:0]       Q_RST   = 2'h0;
  localparam logic [7:0]       SRC_RST = 8'h00;

  typedef enum logic [1:0] {
    LSFU_LOGIC,
    LSFU_RIPPLE,
    LSFU_RAM,
    LSFU_ROM
  } lsfu_mode_t;

  // Restrict a requested mode to what the slice can do
  function automatic lsfu_mode_t lsfu_legal(input int slice, input lsfu_mode_t m,
                                            input logic ram_ok);
    if (slice >= REG_SLICES) begin
      return (m == LSFU_ROM) ? LSFU_ROM : LSFU_LOGIC;
    end else if (m == LSFU_RAM && !ram_ok) begin
      return LSFU_LOGIC;
    end
    return m;
  endfunction
endpackage

// File: hw/lsfu_src_mux.sv
// Region source mux: synchronises the eight secondary source lines and
// picks clock, clock enable and local set/reset. Lines come from pads/routing.
`timescale 1ns/1ps
module lsfu_src_mux
  import lsfu_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  input  wire logic [PAD_SRC-1:0]   src_pad,
  input  wire logic [ROUTE_SRC-1:0] src_route,
  input  wire logic [2:0]           clk_sel,
  input  wire logic [2:0]           ce_sel,
  input  wire logic [2:0]           lsr_sel,
  input  wire logic                 ce_force,
  input  wire logic                 lsr_off,
  output logic                      clk_lvl,
  output logic                      clk_rise,
  output logic                      clk_fall,
  output logic                      ce,
  output logic                      local_set_reset,
  output logic                      sel_err
);
  typedef struct packed {
    logic [SRC_LINES-1:0] s1;
    logic [SRC_LINES-1:0] s2;
    logic [SRC_LINES-1:0] s3;
  } lsfu_mux_st_t;

  lsfu_mux_st_t st_reg;
  lsfu_mux_st_t st_next;
  logic         clk_ok;
  logic         ce_ok;
  logic         lsr_ok;

  // Two flops per line, third only for edge detection
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = {src_route, src_pad};
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '{SRC_RST, SRC_RST, SRC_RST};
    end else begin
      st_reg <= st_next;
    end
  end

  // A line not wired to a role gives nothing rather than a wrong signal
  assign clk_ok   = CLK_LINE_OK[clk_sel];
  assign ce_ok    = CTL_LINE_OK[ce_sel];
  assign lsr_ok   = CTL_LINE_OK[lsr_sel];
  assign clk_lvl  = clk_ok & st_reg.s2[clk_sel];
  assign clk_rise = clk_ok & st_reg.s2[clk_sel] & ~st_reg.s3[clk_sel];
  assign clk_fall = clk_ok & ~st_reg.s2[clk_sel] & st_reg.s3[clk_sel];
  assign ce       = ce_force | (ce_ok & st_reg.s2[ce_sel]);
  assign local_set_reset      = ~lsr_off & lsr_ok & st_reg.s2[lsr_sel];
  assign sel_err  = ~clk_ok | (~ce_force & ~ce_ok) | (~lsr_off & ~lsr_ok);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  chk_clk_line_mask: assert property (!CLK_LINE_OK[clk_sel] |-> !clk_rise && !clk_fall)
    else $error("clock edge from a line not usable as clock");
  chk_ctl_line_mask: assert property (!lsr_off && !CTL_LINE_OK[lsr_sel] |-> !local_set_reset)
    else $error("set/reset from a line not usable as control");
endmodule

// File: hw/lsfu_slice.sv
// One slice: two four-input tables, carry stage and optional register pair.
// Tables, mode and strobes are supplied by the enclosing logic block.
`timescale 1ns/1ps
module lsfu_slice
  import lsfu_pkg::*;
#(
  parameter bit HAS_REG = 1'b1
) (
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  input  wire logic [TBL_W-1:0]  tbl0,
  input  wire logic [TBL_W-1:0]  tbl1,
  input  wire logic [LUT_IN-1:0] lut_a,
  input  wire logic [LUT_IN-1:0] lut_b,
  input  wire logic              m0,
  input  wire lsfu_mode_t        mode,
  input  wire logic              fci,
  input  wire logic              reg_edge,
  input  wire logic              reg_neg,
  input  wire logic              lsr_async,
  input  wire logic [1:0]        init_val,
  input  wire logic              clk_lvl,
  input  wire logic              clk_rise,
  input  wire logic              clk_fall,
  input  wire logic              ce,
  input  wire logic              local_set_reset,
  output logic [1:0]             f,
  output logic                   ofx,
  output logic [1:0]             q,
  output logic                   fco
);
  typedef struct packed {
    logic       init_done;
    logic [1:0] q;
  } lsfu_slc_st_t;

  lsfu_slc_st_t st_reg;
  lsfu_slc_st_t st_next;
  logic         p0;
  logic         p1;
  logic         c1;
  logic         ripple;
  logic         active;

  // Table lookup, ripple sum and carry, in-slice wide select
  assign p0     = tbl0[lut_a];
  assign p1     = tbl1[lut_b];
  assign ripple = HAS_REG && (mode == LSFU_RIPPLE);
  assign c1     = p0 ? fci : lut_a[0];
  assign f      = ripple ? {p1 ^ c1, p0 ^ fci} : {p1, p0};
  assign fco    = ripple ? (p1 ? c1 : lut_b[0]) : 1'b0;
  assign ofx    = m0 ? p1 : p0;

  // Edge or level sensitivity, either polarity, seen on the system clock
  assign active = reg_edge ? (reg_neg ? clk_fall : clk_rise)
                           : (reg_neg ? ~clk_lvl : clk_lvl);

  // First cycle after reset loads the configured preset/clear value
  always_comb begin
    st_next = st_reg;
    if (!st_reg.init_done) begin
      st_next.init_done = 1'b1;
      st_next.q         = init_val;
    end else if (lsr_async && local_set_reset) begin
      st_next.q = init_val;
    end else if (active) begin
      if (local_set_reset) begin
        st_next.q = init_val;
      end else if (ce) begin
        st_next.q = f;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '{1'b0, Q_RST};
    end else begin
      st_reg <= st_next;
    end
  end

  // The top slice has tables only
  assign q = HAS_REG ? st_reg.q : Q_RST;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  chk_init_load: assert property (!st_reg.init_done |=> st_reg.q == $past(init_val))
    else $error("register did not take its configured start value");
  chk_hold_idle: assert property (st_reg.init_done && !active && !(lsr_async && local_set_reset)
                                  |=> $stable(st_reg.q))
    else $error("register changed without an active clock condition");
  chk_ce_load: assert property (st_reg.init_done && active && ce && !local_set_reset |=> st_reg.q == $past(f))
    else $error("enabled register did not capture table output");
  chk_async_lsr: assert property (st_reg.init_done && lsr_async && local_set_reset
                                  |=> st_reg.q == $past(init_val))
    else $error("asynchronous set/reset ignored");
  chk_sync_gate: assert property (st_reg.init_done && !lsr_async && local_set_reset && !active
                                  |=> $stable(st_reg.q))
    else $error("synchronous set/reset acted without clock");
  cov_sync_lsr: cover property (st_reg.init_done && !lsr_async && local_set_reset && active);
endmodule

// File: verif/lsfu_route_model.sv
// Routing-side partner: drives the eight secondary source lines.
// Assumes the bench sets levels and pulse requests just after clk_sys edges.
`timescale 1ns/1ps
module lsfu_route_model
  import lsfu_pkg::*;
(
  input  wire logic [SRC_LINES-1:0] lvl,
  input  wire logic                 pulse,
  input  wire logic [2:0]           pline,
  output logic [PAD_SRC-1:0]        src_pad,
  output logic [ROUTE_SRC-1:0]      src_route
);
  logic [SRC_LINES-1:0] lines;

  // Pulse width is set by the bench, so a slow clock source is easy to mimic
  always_comb begin
    lines        = lvl;
    lines[pline] = lvl[pline] ^ pulse;
  end

  // Low six lines come from pads, the rest from routing
  assign src_pad   = lines[PAD_SRC-1:0];
  assign src_route = lines[SRC_LINES-1:PAD_SRC];
endmodule

// File: verif/lsfu_logic_block_tb_top.sv
// Self-checking bench for the logic block and its region source mux.
// Assumes the routing model makes the source lines; tables are loaded here.
`timescale 1ns/1ps
module lsfu_logic_block_tb_top;
  import lsfu_pkg::*;
  logic                 clk_sys, rstn, ce_force, lsr_off, reg_edge, reg_neg, lsr_async;
  logic                 cfg_we, ram_we, ram_cs, fci, wide_in, pulse, fco, lut7, lut8;
  logic                 mode_err, sel_err, mode_err_lo;
  logic [2:0]           clk_sel, ce_sel, lsr_sel, cfg_sel, pline;
  logic [PAD_SRC-1:0]   src_pad;
  logic [ROUTE_SRC-1:0] src_route;
  logic [5:0]           init_val, ram_wdata, q;
  logic [7:0]           mode_cfg, m_in, f, lvl, f_exp;
  logic [15:0]          cfg_data;
  logic [3:0]           ram_waddr, ofx;
  logic [31:0]          lut_in;
  logic [1:0]           lut6;
  logic [15:0]          tbl [8];
  int                   err_total, samples_checked;
  int                   cycles = 0;
  integer               seed;

  lsfu_logic_block #(.RAM_CAPABLE(1'b1)) dut_u (
    .clk_sys, .rstn, .src_pad, .src_route, .clk_sel, .ce_sel, .lsr_sel, .ce_force,
    .lsr_off, .reg_edge, .reg_neg, .lsr_async, .init_val, .mode_cfg, .cfg_we, .cfg_sel,
    .cfg_data, .ram_we, .ram_cs, .ram_waddr, .ram_wdata, .lut_in, .m_in, .fci, .wide_in,
    .f, .q, .ofx, .fco, .lut6, .lut7, .lut8, .mode_err, .sel_err
  );

  // Logic-only twin on the same inputs, watched for its mode clipping
  lsfu_logic_block #(.RAM_CAPABLE(1'b0)) dut_lo_u (
    .clk_sys, .rstn, .src_pad, .src_route, .clk_sel, .ce_sel, .lsr_sel, .ce_force,
    .lsr_off, .reg_edge, .reg_neg, .lsr_async, .init_val, .mode_cfg, .cfg_we, .cfg_sel,
    .cfg_data, .ram_we, .ram_cs, .ram_waddr, .ram_wdata, .lut_in, .m_in, .fci, .wide_in,
    .f(), .q(), .ofx(), .fco(), .lut6(), .lut7(), .lut8(), .mode_err(mode_err_lo), .sel_err()
  );

  lsfu_route_model route_u (
    .lvl(lvl), .pulse(pulse), .pline(pline), .src_pad(src_pad), .src_route(src_route)
  );

  // 50 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      stop_test();
    end
  end

  // Reference table read: table k is addressed by lut_in[4k+3:4k]
  function automatic logic [7:0] exp_f();
    logic [7:0] r;
    for (int k = 0; k < 8; k++) r[k] = tbl[k][lut_in[4*k +: 4]];
    return r;
  endfunction

  // Reference wide combine: {lut8, lut7, lut6, ofx}
  function automatic logic [7:0] exp_wide();
    logic [7:0] p;
    logic [3:0] o;
    logic [1:0] l6;
    logic       l7;
    p = exp_f();
    for (int s = 0; s < 4; s++) o[s] = m_in[2*s] ? p[2*s+1] : p[2*s];
    l6[0] = m_in[1] ? o[1] : o[0];
    l6[1] = m_in[5] ? o[3] : o[2];
    l7    = m_in[3] ? l6[1] : l6[0];
    return {(m_in[7] ? wide_in : l7), l7, l6, o};
  endfunction

  // Reference ripple: propagate is the table output, generate is bit 0 of that table's input (A, then B)
  function automatic logic [8:0] exp_rip();
    logic [8:0] r;
    logic       c;
    logic       c1;
    logic       p0;
    logic       p1;
    r = {1'b0, exp_f()};
    c = fci;
    for (int s = 0; s < 3; s++) begin
      p0 = r[2*s];
      p1 = r[2*s+1];
      c1 = p0 ? c : lut_in[8*s];
      r[2*s]   = p0 ^ c;
      r[2*s+1] = p1 ^ c1;
      c = p1 ? c1 : lut_in[8*s+4];
    end
    r[8] = c;
    return r;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // One slow clock period on the selected line; covers the sync latency
  task automatic line_clk();
    pulse = 1'b1;
    tick(4);
    pulse = 1'b0;
    tick(4);
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_f();
    cmp({24'h0, f}, {24'h0, exp_f()});
  endtask

  task automatic chk_wide();
    cmp({23'h0, lut8, lut7, lut6, ofx, fco}, {23'h0, exp_wide(), 1'b0});
  endtask

  task automatic chk_rip();
    cmp({23'h0, fco, f}, {23'h0, exp_rip()});
  endtask

  task automatic chk_q(input logic [5:0] e);
    cmp({26'h0, q}, {26'h0, e});
  endtask

  task automatic chk_flag(input logic g, input logic e);
    cmp({31'h0, g}, {31'h0, e});
  endtask

  task automatic stop_test();
    $display("Counts: samples_checked=%0d err_total=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    seed = 32'hE0FF1288;
    err_total = 0;
    samples_checked = 0;
    rstn = 1'b0;
    {ce_force, lsr_off, reg_edge, reg_neg, lsr_async} = 5'h1C;
    {cfg_we, ram_we, ram_cs, fci, wide_in, pulse} = 6'h00;
    {pline, clk_sel, ce_sel, lsr_sel, cfg_sel} = 15'h4201;
    {ram_wdata, ram_waddr, mode_cfg, m_in, lvl} = 34'h0;
    {cfg_data, lut_in} = 48'h0;
    init_val = 6'($random(seed));
    // Reset: registers cleared, then the configured start value
    tick(10);
    chk_q(6'h00);
    tick(10);
    rstn = 1'b1;
    tick(2);
    chk_q(init_val);
    $display("test reset done");
    // Load all eight tables back to back
    for (int k = 0; k < 8; k++) begin
      cfg_we = 1'b1;
      cfg_sel = 3'(k);
      cfg_data = 16'($random(seed));
      tbl[k] = cfg_data;
      tick(1);
    end
    cfg_we = 1'b0;
    repeat (20) begin
      lut_in = $random(seed);
      {m_in, fci, wide_in} = 10'($random(seed));
      #1;
      chk_f();
      chk_wide();
      tick(1);
    end
    $display("test tables done");
    // Slice 3 refuses ripple and RAM; slices 0-2 take RAM
    for (int m = 0; m < 4; m++) begin
      mode_cfg = {2'(m), 6'h2A};
      #1;
      chk_flag(mode_err, m == 1 || m == 2);
      chk_f();
      chk_flag(mode_err_lo, 1'b1);
      tick(1);
    end
    $display("test modes done");
    // Ripple: sums and carry chained through slices 0-2
    mode_cfg = 8'h15;
    repeat (8) begin
      lut_in = $random(seed);
      fci = 1'($random(seed));
      #1;
      chk_rip();
      tick(1);
    end
    mode_cfg = 8'hEA;
    $display("test ripple done");
    // Line roles: only legal lines may be picked as clock or control
    {ce_force, lsr_off} = 2'h0;
    repeat (24) begin
      {clk_sel, ce_sel, lsr_sel} = 9'($random(seed));
      tick(3);
      chk_flag(sel_err, !CLK_LINE_OK[clk_sel] || !CTL_LINE_OK[ce_sel]
               || !CTL_LINE_OK[lsr_sel]);
    end
    $display("test line select done");
    // Register sensitivity: latch/edge and both polarities, enable gating
    {clk_sel, ce_sel, lsr_sel} = 9'h101;
    lvl = 8'h01;
    for (int c = 0; c < 4; c++) begin
      {reg_edge, reg_neg} = 2'(c);
      lut_in = $random(seed);
      line_clk();
      f_exp = exp_f();
      chk_q(f_exp[5:0]);
      lut_in = $random(seed);
      tick(4);
      // Low-transparent latch follows its input while the line idles low
      f_exp = (c == 1) ? exp_f() : f_exp;
      chk_q(f_exp[5:0]);
      lvl[0] = 1'b0;
      line_clk();
      chk_q(f_exp[5:0]);
      lvl[0] = 1'b1;
    end
    $display("test register clocking done");
    // Set/reset: asynchronous acts at once, synchronous waits for the clock
    {reg_edge, reg_neg, lsr_async} = 3'h5;
    lvl[1] = 1'b1;
    tick(5);
    chk_q(init_val);
    lvl[1] = 1'b0;
    line_clk();
    f_exp = exp_f();
    chk_q(f_exp[5:0]);
    {lsr_async, lvl[1]} = 2'h1;
    tick(5);
    chk_q(f_exp[5:0]);
    line_clk();
    chk_q(init_val);
    lvl[1] = 1'b0;
    $display("test set reset done");
    // Distributed memory write, then a write blocked by chip-select
    {ram_we, ram_cs} = 2'h3;
    ram_waddr = 4'($random(seed));
    ram_wdata = 6'($random(seed));
    for (int k = 0; k < 6; k++) tbl[k][ram_waddr] = ram_wdata[k];
    line_clk();
    ram_cs = 1'b0;
    ram_wdata = ~ram_wdata;
    line_clk();
    ram_we = 1'b0;
    lut_in = {8{ram_waddr}};
    #1;
    chk_f();
    $display("test memory write done");
    stop_test();
  end
endmodule
